// File: pbrc_params.svh
`ifndef PBRC_PARAMS_SVH
`define PBRC_PARAMS_SVH

// ****************************************************************
// clock and timebase
// ****************************************************************
`define PBRC_CLK_MHZ      250
`define PBRC_TICK_NS      1000
`define PBRC_TICK_CYCLES  ((`PBRC_TICK_NS * `PBRC_CLK_MHZ) / 1000)
`define PBRC_MS_TICKS     1000

// ****************************************************************
// register map
// ****************************************************************
`define PBRC_ADDR_CFG     8'h00
`define PBRC_ADDR_STATUS  8'h04
`define PBRC_RESP_OKAY    2'h0
`define PBRC_RESP_SLVERR  2'h2

// ****************************************************************
// cfg fields and factory values
// ****************************************************************
`define PBRC_CFG_W        7
`define PBRC_CFG_RESET    7'h54
`define PBRC_STATUS_W     8

// ****************************************************************
// glitch filter times in us
// ****************************************************************
`define PBRC_GLITCH_US0   5'h04
`define PBRC_GLITCH_US1   5'h06
`define PBRC_GLITCH_US2   5'h0A
`define PBRC_GLITCH_US3   5'h12

// ****************************************************************
// reset timeout times in ms
// ****************************************************************
`define PBRC_TIMEOUT_MS0  8'h01
`define PBRC_TIMEOUT_MS1  8'h19
`define PBRC_TIMEOUT_MS2  8'h64
`define PBRC_TIMEOUT_MS3  8'hC8

// ****************************************************************
// push-button hold-down times in ms
// ****************************************************************
`define PBRC_HOLD_MS0     16'h0145
`define PBRC_HOLD_MS1     16'h0271
`define PBRC_HOLD_MS2     16'h04E2
`define PBRC_HOLD_MS3     16'h09C4
`define PBRC_HOLD_MS4     16'h1388
`define PBRC_HOLD_MS5     16'h2710
`define PBRC_HOLD_MS6     16'h4E20
`define PBRC_HOLD_MS7     16'h9C40

// ****************************************************************
// synchroniser lanes
// ****************************************************************
`define PBRC_SYNC_W       6
`define PBRC_IN_BRST      0
`define PBRC_IN_BWARN     1
`define PBRC_IN_BTN       2
`define PBRC_IN_HIGH_VOLTAGE_PROGRAM_PIN      3
`define PBRC_IN_RSTPIN    4
`define PBRC_IN_WARNPIN   5

`endif

// File: pbrc_pkg.sv
package pbrc_pkg;

  typedef struct packed {
    logic [2:0] hold_sel;
    logic [1:0] timeout_sel;
    logic [1:0] glitch_sel;
  } pbrc_cfg_s;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_ASSERT  = 3'b010,
    ST_TIMEOUT = 3'b100
  } pbrc_state_e;

endpackage

// File: pbrc_glitch.sv
`timescale 1ns/1ns
`default_nettype none
module pbrc_glitch
#(
  parameter int CW = 5
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // timebase and comparator
  input  wire logic          tick,
  input  wire logic          raw,
  input  wire logic [CW-1:0] limit,
  // filtered level
  output logic               filt
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  wire           reached = (next_cnt >= limit);

  assign next_cnt = cnt + CW'(1);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt  <= '0;
      filt <= 1'b0;
    end
    else if (!raw)
    begin
      cnt  <= '0;
      filt <= 1'b0;
    end
    else if (tick && !filt)
    begin
      cnt  <= next_cnt;
      filt <= reached;
    end
  end

  chk_glitch_span: assert property (@(posedge clk) disable iff (!resetn)
    $rose(filt) |-> $past(raw) && ($past(next_cnt) >= $past(limit)))
    else $error("filter passed a level before the filter time");

  chk_glitch_drop: assert property (@(posedge clk) disable iff (!resetn)
    !raw |=> !filt && (cnt == '0))
    else $error("filter kept a level after the comparator fell");

endmodule
`default_nettype wire

// File: pbrc_top.sv
`include "pbrc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pbrc_top
  import pbrc_pkg::*;
#(
  parameter int TICK_CYCLES = `PBRC_TICK_CYCLES,
  parameter int MS_TICKS    = `PBRC_MS_TICKS
)
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // comparators and pins
  input  wire logic        SUPPLY_BELOW_RESET,
  input  wire logic        SUPPLY_BELOW_WARN,
  input  wire logic        BUTTON_N,
  input  wire logic        HIGH_VOLTAGE_PROGRAM_PIN,
  // open-drain system reset
  input  wire logic        SYS_RESET_N_I,
  output logic             SYS_RESET_N_O,
  output logic             SYS_RESET_N_OE,
  // open-drain early supply warning
  input  wire logic        EARLY_SUPPLY_WARNING_N_I,
  output logic             EARLY_SUPPLY_WARNING_N_O,
  output logic             EARLY_SUPPLY_WARNING_N_OE,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [`PBRC_SYNC_W-1:0] sync1;
  logic [`PBRC_SYNC_W-1:0] sync2;
  wire  [`PBRC_SYNC_W-1:0] pins = {EARLY_SUPPLY_WARNING_N_I, SYS_RESET_N_I,
                                   HIGH_VOLTAGE_PROGRAM_PIN, BUTTON_N,
                                   SUPPLY_BELOW_WARN, SUPPLY_BELOW_RESET};

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  wire high_voltage_program_pin_mode = sync2[`PBRC_IN_HIGH_VOLTAGE_PROGRAM_PIN];
  wire btn_down  = !sync2[`PBRC_IN_BTN] && !high_voltage_program_pin_mode;

  // ****************************************************************
  // timebase: us tick and ms tick
  // ****************************************************************
  logic [11:0] div_cnt;
  logic [11:0] ms_cnt;
  wire         us_tick = (div_cnt == 12'(TICK_CYCLES - 1));
  wire         ms_tick = us_tick && (ms_cnt == 12'(MS_TICKS - 1));

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      div_cnt <= '0;
      ms_cnt  <= '0;
    end
    else
    begin
      div_cnt <= us_tick ? 12'h000 : div_cnt + 12'h001;
      if (us_tick)
        ms_cnt <= ms_tick ? 12'h000 : ms_cnt + 12'h001;
    end
  end

  // ****************************************************************
  // settings and their lookups
  // ****************************************************************
  pbrc_cfg_s              cfg;
  logic [`PBRC_CFG_W-1:0] high_voltage_program_pin_shift;
  logic                   high_voltage_program_pin_d;
  logic [4:0]             glitch_limit;
  logic [7:0]             timeout_limit;
  logic [15:0]            hold_limit;

  always_comb
  begin
    case (cfg.glitch_sel)
      2'h0:    glitch_limit = `PBRC_GLITCH_US0;
      2'h1:    glitch_limit = `PBRC_GLITCH_US1;
      2'h2:    glitch_limit = `PBRC_GLITCH_US2;
      default: glitch_limit = `PBRC_GLITCH_US3;
    endcase
    case (cfg.timeout_sel)
      2'h0:    timeout_limit = `PBRC_TIMEOUT_MS0;
      2'h1:    timeout_limit = `PBRC_TIMEOUT_MS1;
      2'h2:    timeout_limit = `PBRC_TIMEOUT_MS2;
      default: timeout_limit = `PBRC_TIMEOUT_MS3;
    endcase
    case (cfg.hold_sel)
      3'h0:    hold_limit = `PBRC_HOLD_MS0;
      3'h1:    hold_limit = `PBRC_HOLD_MS1;
      3'h2:    hold_limit = `PBRC_HOLD_MS2;
      3'h3:    hold_limit = `PBRC_HOLD_MS3;
      3'h4:    hold_limit = `PBRC_HOLD_MS4;
      3'h5:    hold_limit = `PBRC_HOLD_MS5;
      3'h6:    hold_limit = `PBRC_HOLD_MS6;
      default: hold_limit = `PBRC_HOLD_MS7;
    endcase
  end

  // ****************************************************************
  // glitch filters, reset lane 0, warning lane 1
  // ****************************************************************
  logic [1:0] filt;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      pbrc_glitch #(.CW(5)) u_filt
      (
        .clk    (CLK),
        .resetn (RESETN),
        .tick   (us_tick),
        .raw    (sync2[g]),
        .limit  (glitch_limit),
        .filt   (filt[g])
      );
    end
  endgenerate

  // ****************************************************************
  // push-button hold-down
  // ****************************************************************
  logic [15:0] hold_cnt;
  logic        btn_fired;
  wire         hold_done = ms_tick && (hold_cnt == hold_limit - 16'h0001);
  wire         btn_trip  = btn_down && !btn_fired && hold_done;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      hold_cnt  <= '0;
      btn_fired <= 1'b0;
    end
    else if (!btn_down)
    begin
      hold_cnt  <= '0;
      btn_fired <= 1'b0;
    end
    else if (ms_tick && !btn_fired)
    begin
      hold_cnt  <= hold_cnt + 16'h0001;
      btn_fired <= hold_done;
    end
  end

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  pbrc_state_e state;
  pbrc_state_e next_state;
  logic [7:0]  tout_cnt;
  wire         cause     = filt[`PBRC_IN_BRST] || btn_trip;
  wire         tout_done = ms_tick && (tout_cnt == timeout_limit - 8'h01);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (cause)
          next_state = ST_ASSERT;
      ST_ASSERT:
        if (!cause)
          next_state = ST_TIMEOUT;
      ST_TIMEOUT:
        if (cause)
          next_state = ST_ASSERT;
        else if (tout_done)
          next_state = ST_RUN;
      default:
        next_state = ST_ASSERT;
    endcase
  end

  wire next_rst  = (next_state != ST_RUN);
  wire next_warn = filt[`PBRC_IN_BWARN] || next_rst;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state                     <= ST_ASSERT;
      tout_cnt                  <= '0;
      SYS_RESET_N_OE            <= 1'b1;
      EARLY_SUPPLY_WARNING_N_OE <= 1'b1;
    end
    else
    begin
      state                     <= next_state;
      tout_cnt                  <= (state != ST_TIMEOUT) ? 8'h00 :
                                   (ms_tick ? tout_cnt + 8'h01 : tout_cnt);
      SYS_RESET_N_OE            <= next_rst;
      EARLY_SUPPLY_WARNING_N_OE <= next_warn;
    end
  end

  assign SYS_RESET_N_O            = 1'b0;
  assign EARLY_SUPPLY_WARNING_N_O = 1'b0;

  // ****************************************************************
  // axi4-lite slave and settings store
  // ****************************************************************
  wire wr_go  = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  wire wr_cfg = wr_go && (S_AXI_AWADDR == `PBRC_ADDR_CFG) && S_AXI_WSTRB[0];
  wire wr_ok  = (S_AXI_AWADDR == `PBRC_ADDR_CFG) || (S_AXI_AWADDR == `PBRC_ADDR_STATUS);
  wire rd_go  = S_AXI_ARVALID && !S_AXI_RVALID;
  wire rd_cfg = (S_AXI_ARADDR == `PBRC_ADDR_CFG);
  wire rd_st  = (S_AXI_ARADDR == `PBRC_ADDR_STATUS);
  wire [`PBRC_STATUS_W-1:0] status = {filt, sync2[`PBRC_IN_WARNPIN], sync2[`PBRC_IN_RSTPIN],
                                      btn_down, high_voltage_program_pin_mode, EARLY_SUPPLY_WARNING_N_OE,
                                      SYS_RESET_N_OE};

  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_ARREADY = rd_go;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cfg          <= `PBRC_CFG_RESET;
      high_voltage_program_pin_shift   <= '0;
      high_voltage_program_pin_d       <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `PBRC_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP  <= `PBRC_RESP_OKAY;
      S_AXI_RDATA  <= '0;
    end
    else
    begin
      high_voltage_program_pin_d <= high_voltage_program_pin_mode;
      if (high_voltage_program_pin_mode && ms_tick)
        high_voltage_program_pin_shift <= {high_voltage_program_pin_shift[`PBRC_CFG_W-2:0], sync2[`PBRC_IN_BTN]};
      if (high_voltage_program_pin_d && !high_voltage_program_pin_mode)
        cfg <= high_voltage_program_pin_shift;
      else if (wr_cfg && !high_voltage_program_pin_mode)
        cfg <= S_AXI_WDATA[`PBRC_CFG_W-1:0];
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `PBRC_RESP_OKAY : `PBRC_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (rd_go)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= (rd_cfg || rd_st) ? `PBRC_RESP_OKAY : `PBRC_RESP_SLVERR;
        S_AXI_RDATA  <= rd_cfg ? 32'(cfg) : (rd_st ? 32'(status) : 32'h00000000);
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  chk_reset_below: assert property (filt[0] |=> SYS_RESET_N_OE)
    else $error("reset not driven while supply low");

  chk_reset_stretch: assert property (
    (state == ST_TIMEOUT) && !tout_done && !cause |=> SYS_RESET_N_OE && (state == ST_TIMEOUT))
    else $error("reset released before timeout");

  chk_warn_below: assert property (filt[1] |=> EARLY_SUPPLY_WARNING_N_OE)
    else $error("warning not driven while supply low");

  chk_warn_first: assert property ($rose(SYS_RESET_N_OE) |-> EARLY_SUPPLY_WARNING_N_OE)
    else $error("reset asserted ahead of warning");

  chk_warn_during: assert property (SYS_RESET_N_OE |-> EARLY_SUPPLY_WARNING_N_OE)
    else $error("warning released during reset");

  chk_button_hold: assert property (
    (state == ST_RUN) && !filt[0] && (hold_cnt < hold_limit - 16'h0001) |=> !SYS_RESET_N_OE)
    else $error("button reset before hold-down");

  chk_button_clear: assert property (!btn_down |=> (hold_cnt == 16'h0000))
    else $error("hold counter kept after release");

  chk_button_stretch: assert property (
    btn_trip |=> ##1 (state == ST_TIMEOUT) && SYS_RESET_N_OE && EARLY_SUPPLY_WARNING_N_OE)
    else $error("button reset not stretched");

  chk_tick_gap: assert property (us_tick |=> !us_tick)
    else $error("timebase tick too close");

  chk_high_voltage_program_pin_quiet: assert property (
    high_voltage_program_pin_mode && (state == ST_RUN) && !filt[0] |=> !SYS_RESET_N_OE)
    else $error("button reset in programming mode");

  chk_open_drain: assert property (!SYS_RESET_N_O && !EARLY_SUPPLY_WARNING_N_O)
    else $error("open-drain output driven high");

  cov_brownout: cover property ($rose(filt[0]) ##[1:8] SYS_RESET_N_OE);
  cov_button:   cover property (btn_trip);
  cov_release:  cover property ($fell(SYS_RESET_N_OE));
  cov_high_voltage_program_pin:     cover property (high_voltage_program_pin_d && !high_voltage_program_pin_mode);

endmodule
`default_nettype wire

// File: pbrc_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pbrc_partner
(
  // open-drain drives from the controller
  input  wire logic rst_oe,
  input  wire logic rst_o,
  input  wire logic warn_oe,
  input  wire logic warn_o,
  // switch contact
  input  wire logic press,
  // resolved levels
  output logic      rst_wire_n,
  output logic      warn_wire_n,
  output logic      button_n
);
  // ****************************************************************
  // wires with pull-ups, switch to ground
  // ****************************************************************
  assign rst_wire_n  = (rst_oe && !rst_o) ? 1'b0 : 1'b1;
  assign warn_wire_n = (warn_oe && !warn_o) ? 1'b0 : 1'b1;
  assign button_n    = press ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: tb_top.sv
`include "pbrc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pbrc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int TC = 4;
  localparam int MT = 4;
  localparam int MS = TC * MT;
  logic        clk, resetn, below_rst, below_warn, high_voltage_program_pin, press;
  logic        rst_oe, rst_o, warn_oe, warn_o, rst_w, warn_w, btn_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, last_rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, last_resp;
  int          n_errors, n_checks, cyc, n;
  int          g [4] = '{4, 6, 10, 18};
  int          tm [4] = '{1, 25, 100, 200};

  pbrc_top #(.TICK_CYCLES(TC), .MS_TICKS(MT)) uut (
    .CLK(clk), .RESETN(resetn),
    .SUPPLY_BELOW_RESET(below_rst), .SUPPLY_BELOW_WARN(below_warn),
    .BUTTON_N(btn_n), .HIGH_VOLTAGE_PROGRAM_PIN(high_voltage_program_pin),
    .SYS_RESET_N_I(rst_w), .SYS_RESET_N_O(rst_o), .SYS_RESET_N_OE(rst_oe),
    .EARLY_SUPPLY_WARNING_N_I(warn_w), .EARLY_SUPPLY_WARNING_N_O(warn_o),
    .EARLY_SUPPLY_WARNING_N_OE(warn_oe),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  pbrc_partner far (
    .rst_oe(rst_oe), .rst_o(rst_o), .warn_oe(warn_oe), .warn_o(warn_o),
    .press(press), .rst_wire_n(rst_w), .warn_wire_n(warn_w), .button_n(btn_n));

  // ****************************************************************
  // clock, report and checks
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= resetn ? cyc + 1 : 0;

  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic stop_wait(input string what);
    n_errors++;
    $display("unexpected %s wait expected done seen timeout", what);
    conclude();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  always @(negedge clk)
    if (resetn)
    begin
      if (rst_oe === 1'b1)
        chk("warning during reset", 1, warn_oe);
      chk("reset wire", !rst_oe, rst_w);
      chk("warning wire", !warn_oe, warn_w);
      chk("drive levels", 0, {rst_o, warn_o});
    end

  // ****************************************************************
  // bus and wait helpers
  // ****************************************************************
  task automatic hs(input int which);
    logic f;
    int   k;
    f = 1'b0;
    k = 0;
    while (!f)
    begin
      @(negedge clk);
      f = which == 0 ? awready && wready : which == 1 ? bvalid : which == 2 ? arready : rvalid;
      last_resp = which == 1 ? bresp : rresp;
      last_rdata = rdata;
      @(posedge clk);
      k++;
      if (k > 50)
        stop_wait("bus");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    bready <= 1'b0;
    chk("write response", r, last_resp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    rready <= 1'b0;
    chk("read response", r, last_resp);
    chk("read data", d, last_rdata);
  endtask

  task automatic wait_oe(input bit w, input logic lvl, input int max);
    n = 0;
    forever
    begin
      @(negedge clk);
      n++;
      if ((w ? warn_oe : rst_oe) === lvl)
        break;
      if (n > max)
        stop_wait("output");
    end
  endtask

  task automatic quiet(input int c, input string what);
    logic f;
    f = 1'b0;
    repeat (c)
    begin
      @(negedge clk);
      f = f | rst_oe | warn_oe;
    end
    chk(what, 0, f);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_power_up();
    chk("power-up outputs", 2'b11, {rst_oe, warn_oe});
    rd(`PBRC_ADDR_CFG, 32'h54, `PBRC_RESP_OKAY);
    wait_oe(0, 0, 30 * MS);
    chk_rng("power-up timeout", 24 * MS, 25 * MS + 8, cyc);
    chk("warning release", 0, warn_oe);
  endtask

  task automatic t_regs();
    wr(`PBRC_ADDR_CFG, 32'h7F, 4'h0, `PBRC_RESP_OKAY);
    rd(`PBRC_ADDR_CFG, 32'h54, `PBRC_RESP_OKAY);
    wr(`PBRC_ADDR_CFG, 32'h04, 4'hF, `PBRC_RESP_OKAY);
    wr(`PBRC_ADDR_STATUS, 32'hFF, 4'hF, `PBRC_RESP_OKAY);
    rd(`PBRC_ADDR_CFG, 32'h04, `PBRC_RESP_OKAY);
    rd(8'h08, 32'h0, `PBRC_RESP_SLVERR);
    rd(`PBRC_ADDR_STATUS, 32'h30, `PBRC_RESP_OKAY);
  endtask

  task automatic pulse(input bit w, input string what);
    @(posedge clk);
    below_rst <= !w;
    below_warn <= w;
    repeat (10) @(posedge clk);
    below_rst <= 1'b0;
    below_warn <= 1'b0;
    quiet(40, what);
  endtask

  task automatic t_dip();
    @(posedge clk);
    below_warn <= 1'b1;
    wait_oe(1, 1, 30);
    chk("reset before warning", 0, rst_oe);
    @(posedge clk);
    below_rst <= 1'b1;
    wait_oe(0, 1, 30);
    @(posedge clk);
    below_rst <= 1'b0;
    below_warn <= 1'b0;
    wait_oe(0, 0, 30 * MS);
    chk_rng("supply timeout", 24 * MS, 25 * MS + 8, n);
  endtask

  task automatic t_filter();
    for (int s = 0; s < 4; s++)
    begin
      wr(`PBRC_ADDR_CFG, {30'h0, 2'(s)}, 4'hF, `PBRC_RESP_OKAY);
      @(posedge clk);
      below_warn <= 1'b1;
      wait_oe(1, 1, 100);
      chk_rng("filter time", (g[s] - 1) * TC + 2, g[s] * TC + 4, n);
      @(posedge clk);
      below_warn <= 1'b0;
      wait_oe(1, 0, 5);
    end
  endtask

  task automatic t_timeout();
    for (int s = 0; s < 4; s++)
    begin
      wr(`PBRC_ADDR_CFG, {28'h0, 2'(s), 2'h0}, 4'hF, `PBRC_RESP_OKAY);
      @(posedge clk);
      below_rst <= 1'b1;
      wait_oe(0, 1, 30);
      @(posedge clk);
      below_rst <= 1'b0;
      wait_oe(0, 0, (tm[s] + 1) * MS);
      chk_rng("timeout length", (tm[s] - 1) * MS, tm[s] * MS + 8, n);
    end
  endtask

  task automatic t_button();
    wr(`PBRC_ADDR_CFG, 32'h04, 4'hF, `PBRC_RESP_OKAY);
    @(posedge clk);
    press <= 1'b1;
    quiet(200 * MS, "short press");
    @(posedge clk);
    press <= 1'b0;
    repeat (4) @(posedge clk);
    press <= 1'b1;
    wait_oe(0, 1, 330 * MS);
    chk_rng("hold-down", 324 * MS, 325 * MS + 8, n);
    chk("button warning", 1, warn_oe);
    @(posedge clk);
    press <= 1'b0;
    wait_oe(0, 0, 30 * MS);
    chk_rng("button timeout", 24 * MS, 25 * MS + 8, n);
  endtask

  task automatic t_high_voltage_program_pin();
    logic [6:0] v;
    v = 7'h15;
    @(posedge clk);
    high_voltage_program_pin <= 1'b1;
    press <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`PBRC_ADDR_STATUS, 32'h34, `PBRC_RESP_OKAY);
    quiet(330 * MS, "button in programming");
    for (int i = 6; i >= 0; i--)
    begin
      @(posedge clk);
      press <= !v[i];
      repeat (MS - 1) @(posedge clk);
    end
    @(posedge clk);
    high_voltage_program_pin <= 1'b0;
    press <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`PBRC_ADDR_CFG, {25'h0, v}, `PBRC_RESP_OKAY);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (60000) @(posedge clk);
    stop_wait("run");
  end

  initial
  begin
    {resetn, below_rst, below_warn, press, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    high_voltage_program_pin = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_power_up();
    t_regs();
    pulse(0, "short reset dip");
    pulse(1, "short warning dip");
    t_dip();
    t_filter();
    t_timeout();
    t_button();
    t_high_voltage_program_pin();
    conclude();
  end
endmodule
`default_nettype wire
